// File: verilog/radio_coexistence_arbiter_cfg.sv
`timescale 1ns/10ps
// Operation
// - Retry timeout ms from option bits 7:0
// - Bit 8 suppresses acks without secure grant
// - Bit 9 aborts transmit when grant drops
// - Bit 12 gives retry request high priority
// - Bit 13 enables request in retry window
// - Bit 14 enables the hold-off input
// - Bit 16 forces request low
// - Bit 17 holds MAC until grant
// - Bits 19:18 pick receive request event
// - Bits 22:20 CCA failure escalation threshold
// - Bits 26:25 MAC failure escalation threshold
// - Value 0x31 byte enables arbitration
// - Value 0x32 carries option word, four bytes
// - Mode byte 00 off, 80 low, 82 high
// - Duty 5 to 95 percent, 1% steps
// - Period codes 10..218 in half milliseconds
// - Directional width 0 off, else microseconds
// - Value 0x35: mode, duty, period bytes
// - Select 00/01,11/10 event encoding
// - Forced holdoff drops request and priority, holds MAC
// - Synchronised MAC waits for grant
module radio_coexistence_arbiter_cfg
  import coex_pkg::*;
#(
  parameter int MS_CYC = MS_NS / CLK_NS,
  parameter logic [31:0] OPTION_RESET = 32'h0,
  parameter logic ENABLE_RESET = 1'b0,
  parameter logic [23:0] PERIODIC_RESET = 24'h0,
  parameter logic [7:0] DIR_WIDTH_RESET = 8'h0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Value get and set
  input wire logic valReqValid,
  input wire value_req_t valReq,
  output logic valRspValid,
  output value_rsp_t valRsp,
  // Radio core
  input wire radio_evt_t radioEvt,
  output logic ackSuppress,
  output logic txAbort,
  output logic macHold,
  // Arbiter pins
  input wire logic grantPin,
  input wire logic radioHoldOffPin,
  output logic requestPin,
  output logic priorityPin,
  output logic dirPriorityPin
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic enableQ;
  logic [31:0] optQ;
  periodic_request_settings_t pwmCfgQ;
  logic [7:0] dirWidthQ;
  logic [2:0] grantSyncQ;
  logic [2:0] holdSyncQ;
  logic grantQ;
  logic holdQ;
  logic grantPrevQ;
  arb_state_t stateQ;
  arb_state_t stateD;
  logic rxAddrQ;
  logic [7:0] retryCntQ;
  logic [31:0] msPreQ;
  logic [CCA_THR_W-1:0] ccaCntQ;
  logic [MAC_THR_W-1:0] macCntQ;
  logic [2:0] expLen;
  logic reqErr;

  // Option fields
  logic [RETRY_TIMEOUT_W-1:0] retryTimeout;
  logic [ASSERT_SEL_W-1:0] assertSel;
  logic [CCA_THR_W-1:0] ccaThr;
  logic [MAC_THR_W-1:0] macThr;
  logic ackSupEn, abortEn, txHighEn, rxHighEn, retryHighEn;
  logic retryReqEn, holdEn, forceHold, macSyncEn;
  assign retryTimeout = optQ[RETRY_TIMEOUT_LSB +: RETRY_TIMEOUT_W];
  assign ackSupEn = optQ[ACK_SUPPRESS_BIT];
  assign abortEn = optQ[TX_ABORT_BIT];
  assign txHighEn = optQ[TX_HIGH_BIT];
  assign rxHighEn = optQ[RX_HIGH_BIT];
  assign retryHighEn = optQ[RETRY_HIGH_BIT];
  assign retryReqEn = optQ[RETRY_REQ_BIT];
  assign holdEn = optQ[HOLD_OFF_EN_BIT];
  assign forceHold = optQ[FORCE_HOLDOFF_BIT];
  assign macSyncEn = optQ[MAC_SYNC_BIT];
  assign assertSel = optQ[ASSERT_SEL_LSB +: ASSERT_SEL_W];
  assign ccaThr = optQ[CCA_THR_LSB +: CCA_THR_W];
  assign macThr = optQ[MAC_THR_LSB +: MAC_THR_W];

  // Value port: length check, one-cycle answer
  function automatic logic [2:0] lenOf(input logic [7:0] id);
    case (id)
      ARBITRATION_ENABLE_ID: lenOf = ENABLE_LEN;
      OPTION_WORD_ID: lenOf = OPTION_LEN;
      PERIODIC_REQUEST_ID: lenOf = PERIODIC_LEN;
      DIRECTIONAL_WIDTH_ID: lenOf = DIR_LEN;
      default: lenOf = 3'h0;
    endcase
  endfunction

  assign expLen = lenOf(valReq.id);
  // Enable accepts only 0 or 1
  assign reqErr = (expLen == 3'h0)
    || (valReq.write && valReq.len != expLen)
    || (valReq.write && valReq.id == ARBITRATION_ENABLE_ID
        && valReq.data[7:0] > 8'h1);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      enableQ <= ENABLE_RESET;
      optQ <= OPTION_RESET & OPTION_WRITABLE;
      pwmCfgQ <= PERIODIC_RESET;
      dirWidthQ <= DIR_WIDTH_RESET;
    end else if (ce && valReqValid && valReq.write && !reqErr) begin
      case (valReq.id)
        ARBITRATION_ENABLE_ID: enableQ <= valReq.data[0];
        // Reserved bits kept zero even if software sets them
        OPTION_WORD_ID: optQ <= valReq.data & OPTION_WRITABLE;
        PERIODIC_REQUEST_ID: pwmCfgQ <= valReq.data[23:0];
        DIRECTIONAL_WIDTH_ID: dirWidthQ <= valReq.data[7:0];
        default: enableQ <= enableQ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      valRspValid <= 1'b0;
      valRsp <= '0;
    end else if (ce) begin
      valRspValid <= valReqValid;
      if (valReqValid) begin
        valRsp.err <= reqErr;
        valRsp.len <= reqErr ? 3'h0 : expLen;
        case (valReq.id)
          ARBITRATION_ENABLE_ID: valRsp.data <= 32'(enableQ);
          OPTION_WORD_ID: valRsp.data <= optQ;
          PERIODIC_REQUEST_ID: valRsp.data <= 32'(pwmCfgQ);
          DIRECTIONAL_WIDTH_ID: valRsp.data <= 32'(dirWidthQ);
          default: valRsp.data <= '0;
        endcase
      end
    end
  end

  // Pin inputs: third stage must agree before a change counts
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      grantSyncQ <= '0;
      holdSyncQ <= '0;
      grantQ <= 1'b0;
      holdQ <= 1'b0;
      grantPrevQ <= 1'b0;
    end else if (ce) begin
      grantSyncQ <= {grantSyncQ[1:0], grantPin};
      holdSyncQ <= {holdSyncQ[1:0], radioHoldOffPin};
      if (grantSyncQ[2] == grantSyncQ[1]) grantQ <= grantSyncQ[2];
      if (holdSyncQ[2] == holdSyncQ[1]) holdQ <= holdSyncQ[2];
      grantPrevQ <= grantQ;
    end
  end

  logic holdActive, grantLost, txAbortD;
  assign holdActive = holdEn && holdQ;
  assign grantLost = grantPrevQ && !grantQ;
  assign txAbortD = enableQ && abortEn && stateQ == S_TX && grantLost;

  always_comb begin
    stateD = stateQ;
    case (stateQ)
      S_IDLE: begin
        if (radioEvt.txStart) stateD = S_TX;
        else if (radioEvt.preamble) stateD = S_RX;
      end
      S_RX: begin
        if (radioEvt.rxEnd) stateD = S_IDLE;
      end
      S_TX: begin
        if (radioEvt.txEnd || txAbortD) stateD = S_IDLE;
      end
      default: stateD = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stateQ <= S_IDLE;
      rxAddrQ <= 1'b0;
    end else if (ce) begin
      stateQ <= stateD;
      rxAddrQ <= (stateD == S_RX) && (rxAddrQ || radioEvt.addrMatch);
    end
  end

  // Receive retry window, counted in whole milliseconds
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      retryCntQ <= '0;
      msPreQ <= '0;
    end else if (ce) begin
      if (radioEvt.retryStart) begin
        retryCntQ <= retryTimeout;
        msPreQ <= '0;
      end else if (retryCntQ != 8'h0) begin
        if (msPreQ == 32'(MS_CYC - 1)) begin
          msPreQ <= '0;
          retryCntQ <= retryCntQ - 8'h1;
        end else begin
          msPreQ <= msPreQ + 32'h1;
        end
      end
    end
  end

  // Escalation counters saturate, cleared by a transmit end without MAC failure
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ccaCntQ <= '0;
      macCntQ <= '0;
    end else if (ce) begin
      if (radioEvt.txEnd && !radioEvt.macFail) begin
        ccaCntQ <= '0;
        macCntQ <= '0;
      end else begin
        if (radioEvt.ccaFail && ccaCntQ != '1)
          ccaCntQ <= ccaCntQ + {{(CCA_THR_W-1){1'b0}}, 1'b1};
        if (radioEvt.macFail && macCntQ != '1)
          macCntQ <= macCntQ + {{(MAC_THR_W-1){1'b0}}, 1'b1};
      end
    end
  end

  logic pwmReq, pwmHigh, escalate;
  logic rxReq, rxPrio, txReq, txPrio, retryReq, retryPrio;
  logic reqD, prioD, dirTrigger;

  periodic_request_gen u_pwm (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .cfg(pwmCfgQ),
    .pwmReq(pwmReq),
    .pwmHigh(pwmHigh)
  );

  assign escalate = (ccaThr != '0 && ccaCntQ >= ccaThr)
    || (macThr != '0 && macCntQ >= macThr);
  assign rxReq = stateQ == S_RX && (assertSel[0] ? rxAddrQ : 1'b1);
  assign rxPrio = stateQ == S_RX && ((assertSel == SEL_SPLIT) ? rxAddrQ
    : (rxReq && rxHighEn));
  assign txReq = radioEvt.txWant || stateQ == S_TX;
  assign txPrio = txReq && (txHighEn || escalate);
  assign retryReq = retryCntQ != 8'h0 && retryReqEn;
  assign retryPrio = retryReq && retryHighEn;
  // Priority is dropped too, so the far end sees a quiet radio
  assign reqD = enableQ && !forceHold
    && (rxReq || txReq || retryReq || pwmReq);
  assign prioD = enableQ && !forceHold
    && (rxPrio || txPrio || retryPrio || pwmHigh);
  assign dirTrigger = reqD && !requestPin && stateQ == S_RX;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      requestPin <= 1'b0;
      priorityPin <= 1'b0;
      ackSuppress <= 1'b0;
      txAbort <= 1'b0;
      macHold <= 1'b0;
    end else if (ce) begin
      requestPin <= reqD;
      priorityPin <= prioD;
      ackSuppress <= enableQ && ackSupEn
        && (!(requestPin && grantQ) || holdActive);
      txAbort <= txAbortD;
      macHold <= enableQ
        && ((macSyncEn && !grantQ) || holdActive || forceHold);
    end
  end

  priority_pulse_gen u_dir (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .trigger(dirTrigger),
    .widthUs(dirWidthQ),
    .pulseOut(dirPriorityPin)
  );

  chk_force_holdoff_req: assert property (
    ce && forceHold |=> !requestPin && !priorityPin)
    else $error("request raised under forced holdoff");
  chk_disabled_quiet: assert property (
    ce && !enableQ |=> !requestPin && !macHold && !ackSuppress)
    else $error("outputs active while arbitration disabled");
  chk_abort_cause: assert property (
    txAbort |-> $past(abortEn) && $past(grantLost))
    else $error("transmit abort without lost grant");
  chk_mac_sync_wait: assert property (
    ce && enableQ && macSyncEn && !grantQ |=> macHold)
    else $error("MAC not held while grant absent");
  chk_retry_load: assert property (
    ce && radioEvt.retryStart |=> retryCntQ == $past(retryTimeout))
    else $error("retry window not loaded from timeout");
  chk_preamble_req: assert property (
    ce && enableQ && !forceHold && stateQ == S_RX
      && assertSel == SEL_PREAMBLE |=> requestPin)
    else $error("request missing at preamble select");
  chk_ack_no_grant: assert property (
    ce && enableQ && ackSupEn && !grantQ |=> ackSuppress)
    else $error("ack not suppressed without grant");
  chk_option_len: assert property (
    ce && valReqValid && valReq.write && valReq.id == OPTION_WORD_ID
      && valReq.len != OPTION_LEN |=> valRspValid && valRsp.err)
    else $error("bad option length accepted");
  chk_enable_set: assert property (
    ce && valReqValid && valReq.write && !reqErr
      && valReq.id == ARBITRATION_ENABLE_ID |=> enableQ == $past(valReq.data[0]))
    else $error("enable value not stored");
endmodule

// File: verilog/coex_pkg.sv
package coex_pkg;
  // Timing
  localparam int CLK_NS = 10;
  localparam int US_NS = 1000;
  localparam int MS_NS = 1000000;
  localparam int HALF_MS_NS = 500000;
  localparam int US_CYC = US_NS / CLK_NS;
  localparam int DUTY_STEPS = 100;
  localparam int PWM_TICK_CYC = HALF_MS_NS / CLK_NS / DUTY_STEPS;

  // Value identifiers and lengths in bytes
  localparam logic [7:0] ARBITRATION_ENABLE_ID = 8'h31;
  localparam logic [7:0] OPTION_WORD_ID = 8'h32;
  localparam logic [7:0] PERIODIC_REQUEST_ID = 8'h35;
  localparam logic [7:0] DIRECTIONAL_WIDTH_ID = 8'h36;
  localparam logic [2:0] ENABLE_LEN = 3'h1;
  localparam logic [2:0] OPTION_LEN = 3'h4;
  localparam logic [2:0] PERIODIC_LEN = 3'h3;
  localparam logic [2:0] DIR_LEN = 3'h1;

  // Option word fields
  localparam int RETRY_TIMEOUT_LSB = 0;
  localparam int RETRY_TIMEOUT_W = 8;
  localparam int ACK_SUPPRESS_BIT = 8;
  localparam int TX_ABORT_BIT = 9;
  localparam int TX_HIGH_BIT = 10;
  localparam int RX_HIGH_BIT = 11;
  localparam int RETRY_HIGH_BIT = 12;
  localparam int RETRY_REQ_BIT = 13;
  localparam int HOLD_OFF_EN_BIT = 14;
  localparam int FORCE_HOLDOFF_BIT = 16;
  localparam int MAC_SYNC_BIT = 17;
  localparam int ASSERT_SEL_LSB = 18;
  localparam int ASSERT_SEL_W = 2;
  localparam int CCA_THR_LSB = 20;
  localparam int CCA_THR_W = 3;
  localparam int MAC_THR_LSB = 25;
  localparam int MAC_THR_W = 2;
  localparam logic [31:0] OPTION_WRITABLE = 32'h067f7fff;
  localparam logic [1:0] SEL_PREAMBLE = 2'h0;
  localparam logic [1:0] SEL_SPLIT = 2'h2;

  // Periodic request coding
  localparam logic [7:0] PWM_OFF = 8'h00;
  localparam logic [7:0] PWM_LOW = 8'h80;
  localparam logic [7:0] PWM_HIGH = 8'h82;
  localparam logic [7:0] DUTY_MIN = 8'h05;
  localparam logic [7:0] DUTY_MAX = 8'h5f;
  localparam logic [7:0] PERIOD_MIN = 8'h0a;
  localparam logic [7:0] PERIOD_MAX = 8'hda;

  // Byte 0 is the mode, in the low bits
  typedef struct packed {
    logic [7:0] interval;
    logic [7:0] duty;
    logic [7:0] mode;
  } periodic_request_settings_t;

  typedef struct packed {
    logic write;
    logic [7:0] id;
    logic [2:0] len;
    logic [31:0] data;
  } value_req_t;

  typedef struct packed {
    logic err;
    logic [2:0] len;
    logic [31:0] data;
  } value_rsp_t;

  typedef struct packed {
    logic preamble;
    logic addrMatch;
    logic rxEnd;
    logic txWant;
    logic txStart;
    logic txEnd;
    logic ccaFail;
    logic macFail;
    logic retryStart;
  } radio_evt_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_RX = 3'h2,
    S_TX = 3'h4
  } arb_state_t;
endpackage

// File: verilog/periodic_request_gen.sv
`timescale 1ns/10ps
module periodic_request_gen
  import coex_pkg::*;
#(
  parameter int TICK_CYC = PWM_TICK_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Settings
  input wire periodic_request_settings_t cfg,
  // Request out
  output logic pwmReq,
  output logic pwmHigh
);
  logic [15:0] tickQ;
  logic [15:0] posQ;
  logic [15:0] posEnd;
  logic [15:0] onEnd;
  logic runs;

  // Out-of-range codes are clamped rather than rejected
  function automatic logic [7:0] clampByte(input logic [7:0] v,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  assign runs = (cfg.mode == PWM_LOW) || (cfg.mode == PWM_HIGH);
  assign posEnd = 16'(clampByte(cfg.interval, PERIOD_MIN, PERIOD_MAX))
    * 16'(DUTY_STEPS);
  assign onEnd = 16'(clampByte(cfg.interval, PERIOD_MIN, PERIOD_MAX))
    * 16'(clampByte(cfg.duty, DUTY_MIN, DUTY_MAX));

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tickQ <= '0;
      posQ <= '0;
    end else if (ce) begin
      if (!runs) begin
        tickQ <= '0;
        posQ <= '0;
      end else if (tickQ == 16'(TICK_CYC - 1)) begin
        tickQ <= '0;
        posQ <= (posQ >= posEnd - 16'h1) ? 16'h0 : posQ + 16'h1;
      end else begin
        tickQ <= tickQ + 16'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pwmReq <= 1'b0;
      pwmHigh <= 1'b0;
    end else if (ce) begin
      pwmReq <= runs && (posQ < onEnd);
      pwmHigh <= (cfg.mode == PWM_HIGH) && (posQ < onEnd);
    end
  end

  chk_pwm_off_idle: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ce && cfg.mode == PWM_OFF |=> !pwmReq && !pwmHigh)
    else $error("periodic request active while disabled");
endmodule

// File: verilog/priority_pulse_gen.sv
`timescale 1ns/10ps
module priority_pulse_gen
  import coex_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Control
  input wire logic trigger,
  input wire logic [7:0] widthUs,
  // Pulse out
  output logic pulseOut
);
  logic [15:0] preQ;
  logic [7:0] remQ;

  // Retrigger restarts the pulse at full width
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      preQ <= '0;
      remQ <= '0;
    end else if (ce) begin
      if (trigger && widthUs != 8'h0) begin
        preQ <= '0;
        remQ <= widthUs;
      end else if (remQ != 8'h0) begin
        if (preQ == 16'(US_CYC - 1)) begin
          preQ <= '0;
          remQ <= remQ - 8'h1;
        end else begin
          preQ <= preQ + 16'h1;
        end
      end
    end
  end

  assign pulseOut = remQ != 8'h0;

  chk_pulse_zero_width: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ce && widthUs == 8'h0 && !pulseOut |=> !pulseOut)
    else $error("directional pulse with zero width");
endmodule

// File: verification/wlan_arbiter_model.sv
`timescale 1ns/10ps
module wlan_arbiter_model #(
  parameter int LAT = 2
) (
  // Clock
  input wire logic core_clk,
  // From the radio
  input wire logic requestPin,
  // Bench controls
  input wire logic deny,
  input wire logic holdOff,
  // To the radio
  output logic grantPin,
  output logic radioHoldOffPin
);
  logic [LAT-1:0] reqDly_q = '0;

  // Grant trails request by LAT cycles and falls LAT cycles after it; deny also takes it away
  always_ff @(posedge core_clk) begin
    reqDly_q <= {reqDly_q[LAT-2:0], requestPin};
  end
  assign grantPin = reqDly_q[LAT-1] & ~deny;
  assign radioHoldOffPin = holdOff;
endmodule

// File: verification/radio_coexistence_arbiter_cfg_test.sv
`timescale 1ns/10ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module radio_coexistence_arbiter_cfg_test;
  import coex_pkg::*;
  // Short millisecond keeps the retry window brief
  localparam int MSC = 20;
  localparam logic [8:0] EV_PRE = 9'h100;
  localparam logic [8:0] EV_ADDR = 9'h080;
  localparam logic [8:0] EV_RXEND = 9'h040;
  localparam logic [8:0] EV_TXSTART = 9'h010;
  localparam logic [8:0] EV_RETRY = 9'h001;
  logic core_clk, rst_n, valReqValid, valRspValid, ackSuppress, txAbort;
  logic macHold, grantPin, radioHoldOffPin, requestPin, priorityPin;
  logic dirPriorityPin, deny, holdOff, ce;
  value_req_t valReq;
  value_rsp_t valRsp;
  radio_evt_t radioEvt;
  int failures, n_compared, cycles, k, ab, dirCnt;

  radio_coexistence_arbiter_cfg #(.MS_CYC(MSC)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce),
    .valReqValid(valReqValid), .valReq(valReq),
    .valRspValid(valRspValid), .valRsp(valRsp), .radioEvt(radioEvt),
    .ackSuppress(ackSuppress), .txAbort(txAbort), .macHold(macHold),
    .grantPin(grantPin), .radioHoldOffPin(radioHoldOffPin),
    .requestPin(requestPin), .priorityPin(priorityPin),
    .dirPriorityPin(dirPriorityPin)
  );

  wlan_arbiter_model u_arb (
    .core_clk(core_clk), .requestPin(requestPin), .deny(deny),
    .holdOff(holdOff), .grantPin(grantPin),
    .radioHoldOffPin(radioHoldOffPin)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (dirPriorityPin === 1'b1) dirCnt++;
    if (cycles == 20000) begin
      failures++;
      $display("unexpected run length: expected < 20000, seen %0d", cycles);
      close_out();
    end
  end

  task automatic close_out;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One request; answer checked while its one-cycle strobe stands
  task automatic acc(input logic w, input logic [7:0] id,
                     input logic [2:0] len, input logic [31:0] d,
                     input logic er, input logic [2:0] el,
                     input logic [31:0] ed);
    @(negedge core_clk);
    valReqValid = 1'b1;
    valReq = '{write: w, id: id, len: len, data: d};
    @(negedge core_clk);
    valReqValid = 1'b0;
    `CHK("answer strobe", 1'b1, valRspValid);
    `CHK("answer error", er, valRsp.err);
    `CHK("answer length", el, valRsp.len);
    if (!w) `CHK("answer data", ed, valRsp.data);
  endtask

  task automatic opt(input logic [31:0] v);
    acc(1'b1, OPTION_WORD_ID, OPTION_LEN, v, 1'b0, OPTION_LEN, 32'h0);
  endtask

  task automatic ena(input logic [31:0] v);
    acc(1'b1, ARBITRATION_ENABLE_ID, ENABLE_LEN, v, 1'b0, ENABLE_LEN, 32'h0);
  endtask

  // Radio pulses keep the queued-frame level as it was
  task automatic evt(input logic [8:0] m);
    @(negedge core_clk);
    radioEvt = radio_evt_t'(m | {3'h0, radioEvt.txWant, 5'h0});
    @(negedge core_clk);
    radioEvt = radio_evt_t'({3'h0, radioEvt.txWant, 5'h0});
  endtask

  task automatic tw(input logic v);
    @(negedge core_clk);
    radioEvt.txWant = v;
  endtask

  initial begin
    rst_n = 1'b0;
    valReqValid = 1'b0;
    valReq = '0;
    radioEvt = '0;
    deny = 1'b0;
    holdOff = 1'b0;
    ce = 1'b1;
    failures = 0;
    n_compared = 0;
    cycles = 0;
    dirCnt = 0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    `CHK("request idle", 1'b0, requestPin);
    acc(1'b0, 8'h31, 3'h1, 0, 1'b0, 3'h1, 32'h0);
    acc(1'b0, 8'h32, 3'h4, 0, 1'b0, 3'h4, 32'h0);
    acc(1'b1, 8'h31, 3'h1, 32'h2, 1'b1, 3'h0, 32'h0);
    acc(1'b1, 8'h32, 3'h2, 32'h1, 1'b1, 3'h0, 32'h0);
    acc(1'b0, 8'h33, 3'h1, 0, 1'b1, 3'h0, 32'h0);
    opt(32'h067f7fff);
    acc(1'b0, 8'h32, 3'h4, 0, 1'b0, 3'h4, 32'h067f7fff);
    acc(1'b1, 8'h35, 3'h3, 32'h0a3200, 1'b0, 3'h3, 32'h0);
    acc(1'b0, 8'h35, 3'h3, 0, 1'b0, 3'h3, 32'h0a3200);
    acc(1'b1, 8'h36, 3'h1, 32'h2, 1'b0, 3'h1, 32'h0);
    acc(1'b0, 8'h36, 3'h1, 0, 1'b0, 3'h1, 32'h2);
    ena(32'h1);
    // Every assert-select code, receive-priority bit as each code needs
    for (k = 0; k < 4; k++) begin
      opt((32'(k) << 18) | (k == 2 ? 32'h0 : 32'h800));
      dirCnt = 0;
      evt(EV_PRE);
      cyc(2);
      `CHK("request at preamble", k[0] == 1'b0, requestPin);
      `CHK("priority at preamble", k == 0, priorityPin);
      evt(EV_ADDR);
      cyc(2);
      `CHK("request at address", 1'b1, requestPin);
      `CHK("priority at address", 1'b1, priorityPin);
      evt(EV_RXEND);
      cyc(300);
      `CHK("request after frame", 1'b0, requestPin);
      `CHK("pulse cycles", 2 * US_CYC, dirCnt);
    end
    opt(32'h10000);
    tw(1'b1);
    cyc(8);
    `CHK("forced request", 1'b0, requestPin);
    `CHK("forced hold", 1'b1, macHold);
    opt(32'h200);
    cyc(8);
    `CHK("queued request", 1'b1, requestPin);
    evt(EV_TXSTART);
    cyc(2);
    @(negedge core_clk);
    deny = 1'b1;
    ab = 0;
    repeat (10) begin
      cyc(1);
      ab += int'(txAbort === 1'b1);
    end
    `CHK("abort pulses", 1, ab);
    deny = 1'b0;
    opt(32'h4100);
    cyc(8);
    `CHK("ack with grant", 1'b0, ackSuppress);
    `CHK("mac free", 1'b0, macHold);
    holdOff = 1'b1;
    cyc(6);
    `CHK("hold-off mac", 1'b1, macHold);
    `CHK("hold-off ack", 1'b1, ackSuppress);
    @(negedge core_clk);
    holdOff = 1'b0;
    deny = 1'b1;
    opt(32'h20000);
    cyc(8);
    `CHK("mac waits", 1'b1, macHold);
    ena(32'h0);
    cyc(3);
    `CHK("disabled request", 1'b0, requestPin);
    `CHK("disabled mac", 1'b0, macHold);
    ena(32'h1);
    @(negedge core_clk);
    deny = 1'b0;
    cyc(8);
    `CHK("mac on grant", 1'b0, macHold);
    tw(1'b0);
    opt(32'h3003);
    cyc(4);
    `CHK("no retry yet", 1'b0, requestPin);
    evt(EV_RETRY);
    cyc(3);
    `CHK("retry request", 1'b1, requestPin);
    `CHK("retry priority", 1'b1, priorityPin);
    // Frozen clock enable stretches the window by 40 cycles
    @(negedge core_clk);
    ce = 1'b0;
    cyc(40);
    `CHK("frozen request", 1'b1, requestPin);
    @(negedge core_clk);
    ce = 1'b1;
    cyc(3 * MSC - 10);
    `CHK("retry window open", 1'b1, requestPin);
    cyc(15);
    `CHK("retry window shut", 1'b0, requestPin);
    opt(32'h0);
    acc(1'b1, 8'h35, 3'h3, 32'h0a3282, 1'b0, 3'h3, 32'h0);
    k = 0;
    while (requestPin !== 1'b1 && k < 3000) begin
      cyc(1);
      k++;
    end
    `CHK("periodic request", 1'b1, requestPin);
    `CHK("periodic high", 1'b1, priorityPin);
    acc(1'b1, 8'h35, 3'h3, 32'h0a3280, 1'b0, 3'h3, 32'h0);
    cyc(3);
    `CHK("periodic low", 1'b0, priorityPin);
    `CHK("periodic on", 1'b1, requestPin);
    acc(1'b1, 8'h35, 3'h3, 32'h0a3200, 1'b0, 3'h3, 32'h0);
    cyc(3);
    `CHK("periodic off", 1'b0, requestPin);
    close_out();
  end
endmodule
